/* File: verilog/aps_sequencer.sv */
// Power-mode sequencer of a serial-clocked converter
// Notes on behaviour
// - Mode 00: powered while select low only
// - Mode 00: select fall starts five-microsecond wake
// - Restored mode 00 powers down at select rise
// - Mode 01: always fully powered
// - First eight clock bits load control word
// - Sample on second rising clock edge
// - Sixteen clock cycles per transfer
// - New transfer accepted right after select rise
// - Mode 10: full shutdown after each conversion
// - Mode 10: first falling clock starts wake
// - Restored mode 10 powers down at end
// - Mode 11: standby keeps reference alive
// - Mode 11: quick wake on first fall
// - Mode 11: standby on last rising edge
// - Power-up in mode 00
// - Mode 00: select rise aborts conversion
// - Auto modes power down on sixteenth rise
`include "aps_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module aps_sequencer #(
    parameter int FIFO_DEPTH = `APS_FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cs_n_pin,
    input wire logic sclk_pin,
    input wire logic din_pin,
    output var aps_pkg::aps_mode_t mode,
    output var aps_pkg::aps_pwr_t pwr_state,
    output var aps_pkg::aps_power_t power,
    output var aps_pkg::aps_event_t evt,
    output logic ctrl_valid,
    input wire logic ctrl_ready,
    output logic [`APS_CTRL_W-1:0] ctrl_data
);
    localparam int WAKE_CYC = `APS_WAKE_CYC;
    localparam int STBY_CYC = `APS_STBY_WAKE_CYC;

    generate
        if (WAKE_CYC >= (1 << `APS_TIMER_W) || STBY_CYC < 1 || FIFO_DEPTH < 2) begin : g_bad
            $error("aps_sequencer: wake counts or FIFO depth out of range");
        end
    endgenerate

    // Pin synchronisers; the first stage feeds only the second
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic cs_prev;
    logic sclk_prev;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pin_meta <= 3'h7;
            pin_sync <= 3'h7;
        end else begin
            pin_meta <= {cs_n_pin, sclk_pin, din_pin};
            pin_sync <= pin_meta;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cs_prev <= 1'b1;
            sclk_prev <= 1'b1;
        end else begin
            cs_prev <= pin_sync[2];
            sclk_prev <= pin_sync[1];
        end
    end

    wire cs_high = pin_sync[2];
    wire sclk_now = pin_sync[1];
    wire din_now = pin_sync[0];
    // Select gates the serial clock: edges count only while it is low
    wire cs_fall = cs_prev && !cs_high;
    wire cs_rise = !cs_prev && cs_high;
    wire sclk_rise = !cs_high && !sclk_prev && sclk_now;
    wire sclk_fall = !cs_high && sclk_prev && !sclk_now;

    // Rising-edge count within the transfer
    logic [`APS_CNT_W-1:0] bit_cnt;
    logic fall_seen;
    logic [`APS_CTRL_W-2:0] ctrl_shift;

    wire [`APS_CNT_W-1:0] next_count =
        (bit_cnt == `APS_XFER_EDGES) ? `APS_CNT_W'(1) : bit_cnt + 1'b1;
    wire at_sample = sclk_rise && (next_count == `APS_SAMPLE_EDGE);
    wire at_end = sclk_rise && (next_count == `APS_XFER_EDGES);
    wire at_load = sclk_rise && (next_count == `APS_CTRL_EDGES);
    wire in_ctrl = sclk_rise && (next_count <= `APS_CTRL_EDGES);
    wire conv_active = (bit_cnt >= `APS_SAMPLE_EDGE) && (bit_cnt < `APS_XFER_EDGES);
    wire first_fall = sclk_fall && !fall_seen;
    wire [`APS_CTRL_W-1:0] ctrl_word = {ctrl_shift, din_now};

    always_ff @(posedge ref_clk) begin
        if (!rst_n || cs_high) begin
            bit_cnt <= '0;
        end else if (sclk_rise) begin
            bit_cnt <= next_count;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n || cs_high || at_end) begin
            fall_seen <= 1'b0;
        end else if (sclk_fall) begin
            fall_seen <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_shift <= '0;
        end else if (in_ctrl) begin
            ctrl_shift <= ctrl_word[`APS_CTRL_W-2:0];
        end
    end

    // A low data input loads all zeros, which selects mode 00
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mode <= aps_pkg::aps_mode_t'(`APS_PM_RESET);
        end else if (at_load) begin
            mode <= aps_pkg::aps_mode_t'({ctrl_word[`APS_PM_HI_POS],
                                          ctrl_word[`APS_PM_LO_POS]});
        end
    end

    // Captured words wait here until the buffer has room; a word held back
    // by a full buffer is replaced by the next capture, never merged
    logic pend_valid;
    logic [`APS_CTRL_W-1:0] pend_word;
    logic fifo_in_ready;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pend_valid <= 1'b0;
            pend_word <= '0;
        end else if (at_load) begin
            pend_valid <= 1'b1;
            pend_word <= ctrl_word;
        end else if (fifo_in_ready) begin
            pend_valid <= 1'b0;
        end
    end

    aps_fifo #(
        .WIDTH(`APS_CTRL_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .in_valid(pend_valid),
        .in_ready(fifo_in_ready),
        .in_data(pend_word),
        .out_valid(ctrl_valid),
        .out_ready(ctrl_ready),
        .out_data(ctrl_data)
    );

    // Power sequencing
    logic [`APS_TIMER_W-1:0] timer;
    aps_pkg::aps_pwr_t next_pwr;
    logic [`APS_TIMER_W-1:0] next_timer;

    wire cs_mode = (mode == aps_pkg::APS_PM_CS);
    wire auto_mode = (mode == aps_pkg::APS_PM_AUTO_OFF) || (mode == aps_pkg::APS_PM_AUTO_STBY);
    wire pwr_low = (pwr_state == aps_pkg::APS_PWR_OFF) || (pwr_state == aps_pkg::APS_PWR_STBY);
    wire cs_off = cs_mode && cs_high && (pwr_state != aps_pkg::APS_PWR_OFF);
    wire end_off = at_end && (mode == aps_pkg::APS_PM_AUTO_OFF);
    wire go_off = cs_off || end_off;
    wire go_stby = at_end && (mode == aps_pkg::APS_PM_AUTO_STBY);
    wire go_wake = pwr_low && ((cs_mode && !cs_high)
                               || (mode == aps_pkg::APS_PM_ON)
                               || (auto_mode && first_fall));
    // Standby keeps the reference up, so its wake is far shorter
    wire [`APS_TIMER_W-1:0] wake_len = (pwr_state == aps_pkg::APS_PWR_STBY)
        ? `APS_TIMER_W'(STBY_CYC) : `APS_TIMER_W'(WAKE_CYC);
    wire wake_done = (pwr_state == aps_pkg::APS_PWR_WAKE) && (timer == `APS_TIMER_W'(1));

    always_comb begin
        next_pwr = pwr_state;
        next_timer = (timer != '0) ? timer - 1'b1 : timer;
        if (go_off) begin
            next_pwr = aps_pkg::APS_PWR_OFF;
            next_timer = '0;
        end else if (go_stby) begin
            next_pwr = aps_pkg::APS_PWR_STBY;
            next_timer = '0;
        end else if (go_wake) begin
            next_pwr = aps_pkg::APS_PWR_WAKE;
            next_timer = wake_len;
        end else if (wake_done) begin
            next_pwr = aps_pkg::APS_PWR_ON;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pwr_state <= aps_pkg::APS_PWR_OFF;
            timer <= '0;
        end else begin
            pwr_state <= next_pwr;
            timer <= next_timer;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            power <= '0;
        end else begin
            power.core_on <= (next_pwr == aps_pkg::APS_PWR_WAKE) || (next_pwr == aps_pkg::APS_PWR_ON);
            power.ref_on <= (next_pwr != aps_pkg::APS_PWR_OFF);
            power.ready <= (next_pwr == aps_pkg::APS_PWR_ON);
        end
    end

    // Sample taken before wake ends is flagged; the host owns that timing
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            evt <= '0;
        end else begin
            evt.sample <= at_sample;
            evt.done <= at_end;
            evt.abort <= cs_mode && cs_rise && conv_active;
            evt.early <= at_sample && (pwr_state != aps_pkg::APS_PWR_ON);
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    a_cs_shutdown: assert property (cs_mode && cs_high |=> pwr_state == aps_pkg::APS_PWR_OFF)
        else $error("select high in mode 00 did not shut down");
    a_cs_wake_start: assert property (cs_mode && cs_fall && pwr_state == aps_pkg::APS_PWR_OFF
        |=> pwr_state == aps_pkg::APS_PWR_WAKE && timer == `APS_TIMER_W'(WAKE_CYC))
        else $error("select fall did not start the long wake");
    a_on_holds: assert property (mode == aps_pkg::APS_PM_ON && pwr_state == aps_pkg::APS_PWR_ON
        && !at_load |=> pwr_state == aps_pkg::APS_PWR_ON)
        else $error("mode 01 left full power");
    a_ctrl_load: assert property (at_load
        |=> mode == aps_pkg::aps_mode_t'({$past(ctrl_shift[0]), $past(din_now)}))
        else $error("control word not loaded on eighth edge");
    a_sample_edge: assert property (sclk_rise && bit_cnt == 5'h01 |=> evt.sample ##1 !evt.sample)
        else $error("sample pulse not on second rising edge");
    a_auto_off: assert property (at_end && mode == aps_pkg::APS_PM_AUTO_OFF
        |=> pwr_state == aps_pkg::APS_PWR_OFF && evt.done && !power.ref_on)
        else $error("auto shutdown missed end of conversion");
    a_stby_entry: assert property (at_end && mode == aps_pkg::APS_PM_AUTO_STBY
        |=> pwr_state == aps_pkg::APS_PWR_STBY ##1 power.ref_on && !power.core_on)
        else $error("standby not entered on last rising edge");
    a_auto_wake: assert property (auto_mode && first_fall && pwr_state == aps_pkg::APS_PWR_OFF
        |=> pwr_state == aps_pkg::APS_PWR_WAKE)
        else $error("first falling edge did not start wake");
    a_stby_quick: assert property (auto_mode && first_fall && pwr_state == aps_pkg::APS_PWR_STBY
        |-> ##[1:3] pwr_state == aps_pkg::APS_PWR_ON)
        else $error("standby wake too slow");
    a_abort_off: assert property (cs_mode && cs_rise && conv_active
        |=> evt.abort && pwr_state == aps_pkg::APS_PWR_OFF)
        else $error("select rise in conversion did not abort");
    a_count_clear: assert property ($rose(cs_high) |=> bit_cnt == '0 && !fall_seen)
        else $error("edge count not cleared at select rise");
    a_wake_length: assert property ($rose(pwr_state == aps_pkg::APS_PWR_WAKE) && timer == 8'h7D
        && !cs_high ##0 (pwr_state == aps_pkg::APS_PWR_WAKE)[*8] |-> timer == 8'h76)
        else $error("wake timer not counting down");

    c_cs_wake: cover property (cs_mode && wake_done);
    c_stby_cycle: cover property (go_stby ##[1:1000] evt.sample);
    c_abort: cover property (evt.abort);
    c_fifo_full: cover property (pend_valid && !fifo_in_ready);
endmodule

`default_nettype wire

/* File: shared/aps_cfg.svh */
// Constants of the power-mode sequencer: field positions, reset values, timing counts
`ifndef APS_CFG_SVH
`define APS_CFG_SVH

`define APS_CLK_MHZ 25
`define APS_WAKE_NS 5000
`define APS_WAKE_CYC ((`APS_WAKE_NS * `APS_CLK_MHZ + 999) / 1000)
`define APS_STBY_WAKE_NS 40
`define APS_STBY_WAKE_CYC ((`APS_STBY_WAKE_NS * `APS_CLK_MHZ + 999) / 1000)
`define APS_TIMER_W 8
`define APS_CNT_W 5
`define APS_XFER_EDGES 5'h10
`define APS_SAMPLE_EDGE 5'h02
`define APS_CTRL_EDGES 5'h08
`define APS_CTRL_W 8
`define APS_PM_HI_POS 1
`define APS_PM_LO_POS 0
`define APS_PM_RESET 2'h0
`define APS_FIFO_DEPTH 4

`endif

/* File: shared/aps_pkg.sv */
// Types shared by the power-mode sequencer and its testbench
package aps_pkg;

    typedef enum logic [1:0] {
        APS_PM_CS = 2'h0,
        APS_PM_ON = 2'h1,
        APS_PM_AUTO_OFF = 2'h2,
        APS_PM_AUTO_STBY = 2'h3
    } aps_mode_t;

    typedef enum logic [1:0] {
        APS_PWR_OFF,
        APS_PWR_STBY,
        APS_PWR_WAKE,
        APS_PWR_ON
    } aps_pwr_t;

    typedef struct packed {
        logic core_on;
        logic ref_on;
        logic ready;
    } aps_power_t;

    typedef struct packed {
        logic sample;
        logic done;
        logic abort;
        logic early;
    } aps_event_t;

endpackage

/* File: verilog/aps_fifo.sv */
// Small flip-flop FIFO for captured control words
`timescale 1ns/1ns
`default_nettype none

module aps_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
            $error("aps_fifo: DEPTH must be a power of two of at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;

    wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    wire empty = (wr_ptr == rd_ptr);
    wire push = in_valid && !full;
    wire pop = out_valid && out_ready;

    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
endmodule

`default_nettype wire

/* File: tb/aps_host_model.sv */
// Host serial master model driving select, serial clock and data
`timescale 1ns/1ns
`default_nettype none

module aps_host_model (
    output logic cs_n,
    output logic sclk,
    output logic din
);
    // Clock idles high so the first edge of a frame is a fall
    initial begin
        cs_n = 1'b1;
        sclk = 1'b1;
        din = 1'b0;
    end

    // One frame of n clocks; the wait after the first rise covers power-up
    task automatic xfer(input logic [7:0] word, input int wake_ns, input int n);
        cs_n = 1'b0;
        #(80);
        for (int i = 0; i < n; i++) begin
            sclk = 1'b0;
            din = (i < 8) ? word[7 - i] : ~din;
            #(160);
            sclk = 1'b1;
            #(160);
            if (i == 0) begin
                #(wake_ns);
            end
        end
    endtask

    // Released data line shows the inverse so stale bits cannot pass
    // Select then stays high long enough for the synchroniser to see the gap
    task automatic release_cs();
        #(80);
        cs_n = 1'b1;
        din = ~din;
        #(160);
    endtask
endmodule
`default_nettype wire

/* File: tb/tb_aps_sequencer.sv */
// Self-checking bench for the power-mode sequencer
`timescale 1ns/1ns
`default_nettype none

module tb_aps_sequencer;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ctrl_ready = 1'b1;
    wire logic cs_n;
    wire logic sclk;
    wire logic din;
    aps_pkg::aps_mode_t mode;
    aps_pkg::aps_pwr_t pwr_state;
    aps_pkg::aps_power_t power;
    aps_pkg::aps_event_t evt;
    logic ctrl_valid;
    logic [7:0] ctrl_data;
    int miscompares = 0;
    int tests_run = 0;
    int n_s = 0;
    int n_d = 0;
    int n_a = 0;
    int n_e = 0;

    always #20 ref_clk = ~ref_clk;

    aps_host_model u_host (.cs_n(cs_n), .sclk(sclk), .din(din));

    aps_sequencer DUT (
        .ref_clk(ref_clk), .rst_n(rst_n), .cs_n_pin(cs_n), .sclk_pin(sclk), .din_pin(din),
        .mode(mode), .pwr_state(pwr_state), .power(power), .evt(evt),
        .ctrl_valid(ctrl_valid), .ctrl_ready(ctrl_ready), .ctrl_data(ctrl_data)
    );

    // Pulses last one cycle, so they are counted rather than polled
    always @(posedge ref_clk) begin
        if (evt.sample === 1'b1) n_s++;
        if (evt.done === 1'b1) n_d++;
        if (evt.abort === 1'b1) n_a++;
        if (evt.early === 1'b1) n_e++;
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic counts(input int s, input int d, input int a, input int e);
        check("samples", 8'(n_s), 8'(s));
        check("dones", 8'(n_d), 8'(d));
        check("aborts", 8'(n_a), 8'(a));
        check("early samples", 8'(n_e), 8'(e));
    endtask

    // Outputs are read one step after the edge, once the new values have settled
    task automatic cycles(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic wait_pwr(input aps_pkg::aps_pwr_t exp, input int lim);
        int k;
        for (k = 0; k < lim && pwr_state !== exp; k++) cycles(1);
        if (pwr_state !== exp) begin
            check("pwr_state wait", 8'(pwr_state), 8'(exp));
            end_sim();
        end
    endtask

    task automatic frame(input logic [7:0] w, input int wake, input int n, input bit rel);
        u_host.xfer(w, wake, n);
        cycles(2);
        if (rel) u_host.release_cs();
    endtask

    task automatic s_select_mode();
        check("reset mode", 8'(mode), 8'h00);
        check("reset pwr", 8'(pwr_state), 8'(aps_pkg::APS_PWR_OFF));
        frame(8'h00, 5200, 16, 1'b0);
        check("powered low", 8'(power), 8'h07);
        counts(1, 1, 0, 0);
        u_host.release_cs();
        wait_pwr(aps_pkg::APS_PWR_OFF, 8);
    endtask

    task automatic s_fast_switch();
        frame(8'h01, 0, 16, 1'b1);
        counts(2, 2, 0, 1);
        check("switched mode", 8'(mode), 8'h01);
        cycles(6);
        check("stays on", 8'(power.core_on), 8'h01);
        wait_pwr(aps_pkg::APS_PWR_ON, 200);
        frame(8'h00, 0, 16, 1'b1);
        counts(3, 3, 0, 1);
        wait_pwr(aps_pkg::APS_PWR_OFF, 8);
    endtask

    task automatic s_abort();
        frame(8'h00, 5200, 5, 1'b1);
        cycles(5);
        counts(4, 3, 1, 1);
        check("abort off", 8'(pwr_state), 8'(aps_pkg::APS_PWR_OFF));
    endtask

    task automatic s_auto_modes();
        frame(8'h02, 5200, 16, 1'b0);
        check("auto off", 8'(pwr_state), 8'(aps_pkg::APS_PWR_OFF));
        cycles(8);
        check("select ignored", 8'(pwr_state), 8'(aps_pkg::APS_PWR_OFF));
        u_host.release_cs();
        frame(8'h02, 5200, 16, 1'b0);
        counts(6, 5, 1, 1);
        check("off again", 8'(pwr_state), 8'(aps_pkg::APS_PWR_OFF));
        u_host.release_cs();
        frame(8'h03, 5200, 16, 1'b1);
        check("standby", 8'(power), 8'h02);
        frame(8'h03, 0, 16, 1'b1);
        counts(8, 7, 1, 1);
        check("standby again", 8'(pwr_state), 8'(aps_pkg::APS_PWR_STBY));
    endtask

    task automatic s_fifo();
        logic [7:0] words [5];
        words = '{8'h01, 8'hA5, 8'h5D, 8'hF1, 8'h11};
        frame(8'h01, 5200, 16, 1'b1);
        cycles(4);
        check("drained", 8'(ctrl_valid), 8'h00);
        @(posedge ref_clk) #1 ctrl_ready = 1'b0;
        // Back-to-back frames with the consumer stalled fill the buffer and leave the fifth word pending
        foreach (words[i]) frame(words[i], 0, 16, 1'b1);
        cycles(4);
        foreach (words[i]) begin
            check("word", ctrl_data, words[i]);
            @(posedge ref_clk) #1 ctrl_ready = 1'b1;
            @(posedge ref_clk) #1 ctrl_ready = 1'b0;
            cycles(2);
        end
        check("empty", 8'(ctrl_valid), 8'h00);
        check("mode kept", 8'(mode), 8'h01);
    endtask

    initial begin
        repeat (2) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        s_select_mode();
        s_fast_switch();
        s_abort();
        s_auto_modes();
        s_fifo();
        end_sim();
    end

    initial begin
        #3000000;
        miscompares++;
        end_sim();
    end
endmodule
`default_nettype wire
